// file: core/fault_bank_map.svh
// Offsets, bit positions, reset values and counts of the fault status bank.
// Assumes inclusion by bare name; definitions only.
`ifndef FAULT_BANK_MAP_SVH
`define FAULT_BANK_MAP_SVH

// Register indices; byte address is four times the index
`define IDX_FAULT_ONE 12'h005
`define IDX_FAULT_TWO 12'h006
`define IDX_ALERT_SUM 12'h007

`define RST_FLAGS 16'h0000
`define RST_WORD 32'h0000_0000

// First fault register
`define B_OSC_A 15
`define B_OSC_B 14
`define B_SE_UP 13
`define B_SE_LO 12
`define B_SE_UP_R 11
`define B_SE_LO_R 10
`define B_RAIL 7
`define B_GND 4
`define B_HV_UV 3
`define B_HDRM 2
`define B_HV_OV 1
`define B_BSW 0
`define F1_STORED_MASK 16'hC3FF

// Second fault register
`define B_USER 15
`define B_MUX 14
`define B_AUX 13
`define B_TEMP 12
`define B_SCAN_TO 11
`define B_ADC_ZS 3
`define B_ADC_FS 2
`define B_COMP_OV 1
`define B_COMP_UV 0
`define F2_STORED_MASK 16'hD00F

// Summary register has no bit 5
`define SUM_VALID_MASK 16'hFFDF

// Slow-clock rising edges per drift evaluation
`define OSC_EVAL_EDGES 2'h2

`define SCAN_CFG_A 3'h1
`define SCAN_CFG_B 3'h2
`define CB_STATE_IDLE 2'h0
`define CB_STATE_THERMAL 2'h3

`endif

// file: core/fault_bank_pkg.sv
// Types of the fault status bank.
// Assumes the map header supplies all numbers.
package fault_bank_pkg;

  // Levels arriving from analog comparators and other clocks
  typedef struct packed {
    logic slow_clk;
    logic osc_drift_a;
    logic osc_drift_b;
    logic upper_se;
    logic lower_se;
    logic [2:0] rail_low;
    logic [2:0] gnd_open;
    logic hv_uv;
    logic hv_ov;
    logic headroom_low;
    logic mux_fault;
    logic overtemp;
  } cond_s;

  // Results of the acquisition engine, same clock
  typedef struct packed {
    logic acq_done;
    logic zs_fail;
    logic fs_fail;
    logic comp_done;
    logic comp_ov_fail;
    logic comp_uv_fail;
  } acq_s;

  typedef struct packed {
    cond_s meta;
    cond_s sync;
  } sync_s;

  typedef struct packed {
    logic [15:0] f1;
    logic [15:0] f2;
    logic [15:0] sum;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
    logic [1:0] osc_cnt;
    logic slow_prev;
    logic temp_prev;
    logic cb_stop;
    logic [1:0] cb_state;
    logic cb_thermal;
  } bank_s;

endpackage : fault_bank_pkg

// file: core/cond_sync.sv
// Two-flop synchroniser for the asynchronous condition levels.
// Assumes pclk domain and the shared clock enable.
`timescale 1ns/1ps
module cond_sync (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // Levels
  input wire fault_bank_pkg::cond_s cond_in,
  output fault_bank_pkg::cond_s cond_out
);

  fault_bank_pkg::sync_s st_q;
  fault_bank_pkg::sync_s st_d;

  // First stage feeds only the second stage
  always_comb begin
    st_d = st_q;
    if (ce) begin
      st_d.meta = cond_in;
      st_d.sync = st_q.meta;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign cond_out = st_q.sync;

endmodule : cond_sync

// file: core/fault_alert_status_bank.sv
// Fault and alert status registers behind an APB slave.
// Assumes condition pins are asynchronous, engine inputs share pclk.
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`include "fault_bank_map.svh"

// Summary of operation
// - Slow-oscillator drift sets bit 15, evaluated every two slow-clock cycles.
// - Redundant drift flag at bit 14 latched independently.
// - Write zero clears oscillator flags only once drift has gone.
// - Read-only single-ended flags at 13 and 12, held off by power-on alert.
// - Redundant single-ended flags at 11 and 10, no power-on hold-off.
// - Logic rail low flags 9..7, held off, cleared by zero once rail recovers.
// - Ground open flags 6..4, held off, cleared by zero unconditionally.
// - Supply under and overvoltage at 3 and 1, held off, zero clears.
// - Headroom fault at bit 2 checked only while measuring; zero clears.
// - Bit 0 is OR of switch faults at scan end; clears when resolved or zero.
// - User test alert bit 15 written directly; relayed on alert output.
// - Supply mux fault needs pack enable and clear power-on alert.
// - Aux protection summary is OR of enabled aux alerts, read-only.
// - Die overtemperature sets bit 12; only zero write clears.
// - Overtemperature during automated balancing ends it, state 11, thermal alert.
// - Scan timeout mirror when timeout not disabled, read-only.
// - ADC zero and full scale self-test failures at 3 and 2 when enabled.
// - Comparator accuracy failures at 1 and 0 for configurations 001 or 010.
// - Read-only alert summary register at index 7, resets to zero.
// - Writing one to a clear-by-zero flag changes nothing.
module fault_alert_status_bank (
  // Clock, reset, freeze
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Asynchronous condition levels
  input wire fault_bank_pkg::cond_s cond_pin,
  // Engine status, same clock
  input wire logic power_on_alert_flag,
  input wire logic meas_active,
  input wire logic [13:0] balance_switch_fault,
  input wire logic switch_diagnostic_scan_done,
  input wire logic flexible_pack_enable,
  input wire logic [3:0] aux_protection_alerts,
  input wire logic scan_timeout_flag,
  input wire logic scan_timeout_disable,
  input wire logic adc_selftest_enable,
  input wire logic comparator_accuracy_enable,
  input wire logic [2:0] scan_configuration,
  input wire fault_bank_pkg::acq_s acq,
  input wire logic [15:0] alert_summary_in,
  // Balancing engine
  input wire logic balance_auto_active,
  input wire logic balance_start,
  output logic balance_stop,
  output logic [1:0] balancing_active_state,
  output logic balancing_thermal_alert,
  // Alert relay
  output logic user_test_alert
);

  localparam logic [11:0] ADDR_F1 = `IDX_FAULT_ONE * 12'h004;
  localparam logic [11:0] ADDR_F2 = `IDX_FAULT_TWO * 12'h004;
  localparam logic [11:0] ADDR_SUM = `IDX_ALERT_SUM * 12'h004;

  fault_bank_pkg::bank_s bank_q;
  fault_bank_pkg::bank_s bank_d;
  fault_bank_pkg::cond_s s;

  logic access;
  logic take;
  logic wr_f1;
  logic wr_f2;
  logic por_clear;
  logic slow_rise;
  logic osc_eval;
  logic temp_rise;
  logic comp_run;
  logic aux_sum;
  logic scan_to;
  logic [15:0] f1_view;
  logic [15:0] f2_view;
  logic [15:0] f1_set;
  logic [15:0] f1_clr;
  logic [15:0] f2_set;
  logic [15:0] f2_clr;

  cond_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .cond_in(cond_pin),
    .cond_out(s)
  );

  always_comb begin
    access = psel & penable;
    // Write lands at the edge where pready is seen high
    take = ce & access & bank_q.ready;
    wr_f1 = take & pwrite & (paddr == ADDR_F1);
    wr_f2 = take & pwrite & (paddr == ADDR_F2);
    por_clear = ~power_on_alert_flag;
    slow_rise = s.slow_clk & ~bank_q.slow_prev;
    osc_eval = ce & slow_rise & (bank_q.osc_cnt == (`OSC_EVAL_EDGES - 2'h1));
    temp_rise = s.overtemp & ~bank_q.temp_prev;
    comp_run = comparator_accuracy_enable &
      ((scan_configuration == `SCAN_CFG_A) | (scan_configuration == `SCAN_CFG_B));
    aux_sum = |aux_protection_alerts;
    scan_to = scan_timeout_flag & ~scan_timeout_disable;

    f1_view = bank_q.f1 & `F1_STORED_MASK;
    f1_view[`B_SE_UP] = s.upper_se & por_clear;
    f1_view[`B_SE_LO] = s.lower_se & por_clear;
    f1_view[`B_SE_UP_R] = s.upper_se;
    f1_view[`B_SE_LO_R] = s.lower_se;
    f2_view = bank_q.f2 & `F2_STORED_MASK;
    f2_view[`B_AUX] = aux_sum;
    f2_view[`B_SCAN_TO] = scan_to;

    f1_set = `RST_FLAGS;
    f1_set[`B_OSC_A] = osc_eval & s.osc_drift_a;
    f1_set[`B_OSC_B] = osc_eval & s.osc_drift_b;
    f1_set[`B_RAIL +: 3] = s.rail_low & {3{por_clear}};
    f1_set[`B_GND +: 3] = s.gnd_open & {3{por_clear}};
    f1_set[`B_HV_UV] = s.hv_uv & por_clear;
    f1_set[`B_HV_OV] = s.hv_ov & por_clear;
    f1_set[`B_HDRM] = s.headroom_low & meas_active;

    // Only a zero clears; a one leaves the flag alone
    f1_clr = wr_f1 ? ~pwdata[15:0] : `RST_FLAGS;
    f1_clr[`B_OSC_A] = f1_clr[`B_OSC_A] & ~s.osc_drift_a;
    f1_clr[`B_OSC_B] = f1_clr[`B_OSC_B] & ~s.osc_drift_b;
    f1_clr[`B_RAIL +: 3] = f1_clr[`B_RAIL +: 3] & ~s.rail_low;

    f2_set = `RST_FLAGS;
    f2_set[`B_MUX] = s.mux_fault & flexible_pack_enable & por_clear;
    f2_set[`B_TEMP] = s.overtemp;
    f2_set[`B_ADC_ZS] = acq.acq_done & adc_selftest_enable & acq.zs_fail;
    f2_set[`B_ADC_FS] = acq.acq_done & adc_selftest_enable & acq.fs_fail;
    f2_set[`B_COMP_OV] = acq.comp_done & comp_run & acq.comp_ov_fail;
    f2_set[`B_COMP_UV] = acq.comp_done & comp_run & acq.comp_uv_fail;

    f2_clr = wr_f2 ? ~pwdata[15:0] : `RST_FLAGS;
    f2_clr[`B_MUX] = f2_clr[`B_MUX] & ~(s.mux_fault & flexible_pack_enable);
  end

  always_comb begin
    bank_d = bank_q;
    if (ce) begin
      // Set wins over a clear landing in the same cycle
      bank_d.f1 = ((bank_q.f1 & ~f1_clr) | f1_set) & `F1_STORED_MASK;
      bank_d.f2 = ((bank_q.f2 & ~f2_clr) | f2_set) & `F2_STORED_MASK;
      if (switch_diagnostic_scan_done) begin
        bank_d.f1[`B_BSW] = |balance_switch_fault;
      end else if (~|balance_switch_fault) begin
        bank_d.f1[`B_BSW] = 1'b0;
      end
      bank_d.f2[`B_USER] = wr_f2 ? pwdata[`B_USER] : bank_q.f2[`B_USER];
      bank_d.sum = alert_summary_in & `SUM_VALID_MASK;

      // Drift evaluation cadence on the synchronised slow clock
      bank_d.slow_prev = s.slow_clk;
      if (slow_rise) begin
        bank_d.osc_cnt = osc_eval ? 2'h0 : bank_q.osc_cnt + 2'h1;
      end

      // Thermal stop of automated balancing or discharge
      bank_d.temp_prev = s.overtemp;
      bank_d.cb_stop = 1'b0;
      if (balance_start) begin
        bank_d.cb_state = `CB_STATE_IDLE;
        bank_d.cb_thermal = 1'b0;
      end else if (temp_rise & balance_auto_active) begin
        bank_d.cb_stop = 1'b1;
        bank_d.cb_state = `CB_STATE_THERMAL;
        bank_d.cb_thermal = 1'b1;
      end

      // One wait state: read data and error prepared with pready
      bank_d.ready = access & ~bank_q.ready;
      bank_d.rdata = `RST_WORD;
      bank_d.slverr = 1'b0;
      if (access & ~bank_q.ready) begin
        unique case (paddr)
          ADDR_F1: bank_d.rdata = {16'h0000, f1_view};
          ADDR_F2: bank_d.rdata = {16'h0000, f2_view};
          ADDR_SUM: bank_d.rdata = {16'h0000, bank_q.sum};
          default: bank_d.slverr = 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank_q <= '0;
    end else begin
      bank_q <= bank_d;
    end
  end

  always_comb begin
    prdata = bank_q.rdata;
    pready = bank_q.ready;
    pslverr = bank_q.slverr;
    user_test_alert = bank_q.f2[`B_USER];
    balance_stop = bank_q.cb_stop;
    balancing_active_state = bank_q.cb_state;
    balancing_thermal_alert = bank_q.cb_thermal;
  end

  default clocking cb_chk @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_osc_held: assert property (
    wr_f1 && !pwdata[`B_OSC_A] && s.osc_drift_a && bank_q.f1[`B_OSC_A]
    |=> bank_q.f1[`B_OSC_A])
    else $error("oscillator flag cleared while drift present");

  chk_osc_cadence: assert property (
    $rose(bank_q.f1[`B_OSC_A]) |-> $past(osc_eval))
    else $error("oscillator flag set outside evaluation tick");

  chk_rail_holdoff: assert property (
    ce && power_on_alert_flag && !bank_q.f1[`B_RAIL] && !wr_f1
    |=> !bank_q.f1[`B_RAIL])
    else $error("rail flag set while power-on alert pending");

  chk_gnd_clear: assert property (
    wr_f1 && !pwdata[`B_GND] && !f1_set[`B_GND] |=> !bank_q.f1[`B_GND])
    else $error("ground flag not cleared by zero write");

  chk_hdrm_active: assert property (
    $rose(bank_q.f1[`B_HDRM]) |-> $past(meas_active))
    else $error("headroom flag set outside measurement");

  chk_bsw_update: assert property (
    ce && switch_diagnostic_scan_done
    |=> bank_q.f1[`B_BSW] == $past(|balance_switch_fault))
    else $error("switch summary not updated at scan end");

  chk_user_write: assert property (
    wr_f2 |=> user_test_alert == $past(pwdata[`B_USER]))
    else $error("user alert does not follow write");

  chk_temp_one: assert property (
    wr_f2 && pwdata[`B_TEMP] && !bank_q.f2[`B_TEMP] && !s.overtemp
    |=> !bank_q.f2[`B_TEMP])
    else $error("writing one set overtemperature flag");

  chk_cb_stop: assert property (
    ce && temp_rise && balance_auto_active && !balance_start
    |=> balance_stop && balancing_active_state == `CB_STATE_THERMAL
        && balancing_thermal_alert)
    else $error("balancing not stopped on overtemperature");

  chk_zs_report: assert property (
    ce && acq.acq_done && adc_selftest_enable && acq.zs_fail |=> bank_q.f2[`B_ADC_ZS])
    else $error("zero-scale failure not reported");

  chk_comp_cfg: assert property (
    ce && acq.comp_done && !comp_run && !bank_q.f2[`B_COMP_OV]
    |=> !bank_q.f2[`B_COMP_OV])
    else $error("comparator flag set with test not enabled");

  chk_apb_wait: assert property (
    ce && access && !pready |=> pready ##0 prdata[31:16] == 16'h0000)
    else $error("slave did not answer after one wait state");

  chk_osc_b_cadence: assert property (
    $rose(bank_q.f1[`B_OSC_B]) |-> $past(osc_eval) && $past(s.osc_drift_b))
    else $error("redundant oscillator flag set outside evaluation tick");

  chk_se_holdoff: assert property (
    ce && access && !pready && (paddr == ADDR_F1) && power_on_alert_flag
    |=> prdata[`B_SE_LO +: 2] == 2'b00)
    else $error("single-ended flag read while power-on alert pending");

  chk_se_redundant: assert property (
    ce && access && !pready && (paddr == ADDR_F1)
    |=> prdata[`B_SE_LO_R +: 2] == $past({s.upper_se, s.lower_se}))
    else $error("redundant single-ended flags do not follow receiver");

  chk_hv_holdoff: assert property (
    ce && power_on_alert_flag && !bank_q.f1[`B_HV_UV] |=> !bank_q.f1[`B_HV_UV])
    else $error("undervoltage flag set while power-on alert pending");

  chk_bsw_resolve: assert property (
    ce && !switch_diagnostic_scan_done && !(|balance_switch_fault)
    |=> !bank_q.f1[`B_BSW])
    else $error("switch summary kept with all faults resolved");

  chk_mux_held: assert property (
    wr_f2 && !pwdata[`B_MUX] && bank_q.f2[`B_MUX] && s.mux_fault && flexible_pack_enable
    |=> bank_q.f2[`B_MUX])
    else $error("mux flag cleared while fault present");

  chk_aux_summary: assert property (
    ce && access && !pready && (paddr == ADDR_F2)
    |=> prdata[`B_AUX] == $past(|aux_protection_alerts))
    else $error("aux summary does not follow aux alerts");

  chk_temp_clear: assert property (
    wr_f2 && !pwdata[`B_TEMP] && !s.overtemp |=> !bank_q.f2[`B_TEMP])
    else $error("overtemperature flag not cleared by zero write");

  chk_scan_mirror: assert property (
    ce && access && !pready && (paddr == ADDR_F2)
    |=> prdata[`B_SCAN_TO] == $past(scan_timeout_flag && !scan_timeout_disable))
    else $error("scan timeout mirror wrong");

  chk_fs_report: assert property (
    ce && acq.acq_done && adc_selftest_enable && acq.fs_fail |=> bank_q.f2[`B_ADC_FS])
    else $error("full-scale failure not reported");

  chk_comp_report: assert property (
    ce && acq.comp_done && comp_run && acq.comp_uv_fail |=> bank_q.f2[`B_COMP_UV])
    else $error("comparator low failure not reported");

  chk_sum_gap: assert property (
    ce && access && !pready && (paddr == ADDR_SUM)
    |=> (prdata[15:0] & ~`SUM_VALID_MASK) == 16'h0000)
    else $error("unused summary bit read as one");

  chk_bad_addr: assert property (
    ce && access && !pready && (paddr != ADDR_F1)
    && (paddr != ADDR_F2) && (paddr != ADDR_SUM)
    |=> pslverr && prdata == `RST_WORD)
    else $error("unmapped address not refused");

  chk_freeze_all: assert property (
    !ce |=> bank_q == $past(bank_q))
    else $error("state moved while clock enable low");

  cov_user_write: cover property (wr_f2 && pwdata[`B_USER]);
  cov_osc_set: cover property ($rose(bank_q.f1[`B_OSC_A]));
  cov_cb_stop: cover property (balance_stop);
  cov_bad_addr: cover property (pready && pslverr);
  cov_ce_freeze: cover property (!ce && switch_diagnostic_scan_done);

endmodule : fault_alert_status_bank

// file: dv/fault_alert_status_bank_bench.sv
// Self-checking bench for the fault and alert status bank.
// Assumes an APB slave that answers within a few cycles, one clock domain.
`timescale 1ns/1ps
`include "fault_bank_map.svh"
module fault_alert_status_bank_bench;
  localparam logic [11:0] A1 = `IDX_FAULT_ONE << 2;
  localparam logic [11:0] A2 = `IDX_FAULT_TWO << 2;
  localparam logic [11:0] AS = `IDX_ALERT_SUM << 2;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rv;
  logic pready, pslverr, re;
  fault_bank_pkg::cond_s cond = '0;
  fault_bank_pkg::acq_s acq = '0;
  logic poa = 1'b1, meas = 1'b0, scan_done = 1'b0, fpe = 1'b0;
  logic to_flag = 1'b0, to_dis = 1'b0, st_en = 1'b0, ca_en = 1'b0;
  logic auto_act = 1'b0, bstart = 1'b0;
  logic ce = 1'b1;
  logic [13:0] bsw = 14'h0000;
  logic [3:0] aux = 4'h0;
  logic [2:0] cfg = 3'h0;
  logic [15:0] sum_in = 16'h0000;
  logic bstop, thermal, user_alert;
  logic [1:0] bstate;
  int n_fail = 0;
  int comparisons = 0;
  int cyc = 0;
  int n_stop = 0;

  always #25 pclk = ~pclk;

  fault_alert_status_bank DUT (
    .pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cond_pin(cond), .power_on_alert_flag(poa), .meas_active(meas),
    .balance_switch_fault(bsw), .switch_diagnostic_scan_done(scan_done),
    .flexible_pack_enable(fpe), .aux_protection_alerts(aux),
    .scan_timeout_flag(to_flag), .scan_timeout_disable(to_dis),
    .adc_selftest_enable(st_en), .comparator_accuracy_enable(ca_en),
    .scan_configuration(cfg), .acq(acq), .alert_summary_in(sum_in),
    .balance_auto_active(auto_act), .balance_start(bstart), .balance_stop(bstop),
    .balancing_active_state(bstate), .balancing_thermal_alert(thermal),
    .user_test_alert(user_alert)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict();
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict

  // Request held until pready is sampled high; no latency assumed
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rv = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [15:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(rv, {16'h0000, exp});
  endtask : rd

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    apb(1'b1, a, {16'h0000, d});
  endtask : wr

  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask : idle

  task automatic pulse_scan();
    scan_done <= 1'b1;
    @(posedge pclk);
    scan_done <= 1'b0;
    @(posedge pclk);
  endtask : pulse_scan

  always @(posedge pclk) begin
    cyc++;
    if (bstop === 1'b1) begin
      n_stop++;
    end
    if (cyc == 5000) begin
      n_fail++;
      give_verdict();
    end
  end

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(A1, 16'h0000);
    rd(A2, 16'h0000);
    rd(AS, 16'h0000);
    apb(1'b0, 12'h020, 32'h0000_0000);
    check({31'h0, re}, 32'h0000_0001);
    check(rv, 32'h0000_0000);
    // Power-on alert still pending: only redundant flags may show
    cond.gnd_open <= 3'h7;
    cond.upper_se <= 1'b1;
    cond.lower_se <= 1'b1;
    idle(4);
    rd(A1, 16'h0C00);
    poa <= 1'b0;
    idle(4);
    rd(A1, 16'h3C70);
    cond.gnd_open <= 3'h0;
    cond.upper_se <= 1'b0;
    cond.lower_se <= 1'b0;
    idle(4);
    wr(A1, 16'hFFFF);
    rd(A1, 16'h0070);
    wr(A1, 16'h0000);
    rd(A1, 16'h0000);
    // Slow clock toggled by hand, four rising edges
    cond.osc_drift_a <= 1'b1;
    cond.osc_drift_b <= 1'b1;
    cond.rail_low <= 3'h7;
    repeat (8) begin
      idle(4);
      cond.slow_clk <= ~cond.slow_clk;
    end
    idle(4);
    rd(A1, 16'hC380);
    wr(A1, 16'h0000);
    rd(A1, 16'hC380);
    cond.osc_drift_a <= 1'b0;
    cond.rail_low <= 3'h0;
    idle(4);
    wr(A1, 16'h0000);
    rd(A1, 16'h4000);
    cond.osc_drift_b <= 1'b0;
    idle(4);
    wr(A1, 16'h0000);
    rd(A1, 16'h0000);
    cond.hv_uv <= 1'b1;
    cond.hv_ov <= 1'b1;
    cond.headroom_low <= 1'b1;
    idle(4);
    rd(A1, 16'h000A);
    meas <= 1'b1;
    idle(2);
    rd(A1, 16'h000E);
    cond.hv_uv <= 1'b0;
    cond.hv_ov <= 1'b0;
    cond.headroom_low <= 1'b0;
    meas <= 1'b0;
    idle(4);
    wr(A1, 16'hFFFF);
    rd(A1, 16'h000E);
    wr(A1, 16'h0000);
    rd(A1, 16'h0000);
    bsw <= 14'h2000;
    idle(1);
    pulse_scan();
    rd(A1, 16'h0001);
    bsw <= 14'h0000;
    idle(2);
    rd(A1, 16'h0000);
    // Scan end while frozen is lost; zero write clears a standing fault
    bsw <= 14'h0001;
    ce <= 1'b0;
    pulse_scan();
    ce <= 1'b1;
    rd(A1, 16'h0000);
    pulse_scan();
    rd(A1, 16'h0001);
    wr(A1, 16'h0000);
    rd(A1, 16'h0000);
    bsw <= 14'h0000;
    wr(A2, 16'h8000);
    rd(A2, 16'h8000);
    check({31'h0, user_alert}, 32'h0000_0001);
    wr(A2, 16'h0000);
    rd(A2, 16'h0000);
    fpe <= 1'b1;
    cond.mux_fault <= 1'b1;
    aux <= 4'h2;
    to_flag <= 1'b1;
    auto_act <= 1'b1;
    cond.overtemp <= 1'b1;
    idle(4);
    rd(A2, 16'h7800);
    check({30'h0, bstate}, 32'h0000_0003);
    check({31'h0, thermal}, 32'h0000_0001);
    check(n_stop, 32'h0000_0001);
    bstart <= 1'b1;
    idle(1);
    bstart <= 1'b0;
    idle(1);
    check({30'h0, bstate}, 32'h0000_0000);
    check({31'h0, thermal}, 32'h0000_0000);
    wr(A2, 16'h0000);
    rd(A2, 16'h7800);
    cond.mux_fault <= 1'b0;
    cond.overtemp <= 1'b0;
    aux <= 4'h0;
    to_dis <= 1'b1;
    idle(4);
    rd(A2, 16'h5000);
    wr(A2, 16'h5000);
    rd(A2, 16'h5000);
    wr(A2, 16'h0000);
    rd(A2, 16'h0000);
    st_en <= 1'b1;
    acq.zs_fail <= 1'b1;
    acq.fs_fail <= 1'b1;
    acq.acq_done <= 1'b1;
    idle(1);
    acq.acq_done <= 1'b0;
    rd(A2, 16'h000C);
    wr(A2, 16'h0000);
    rd(A2, 16'h0000);
    // Every scan configuration; only two of them run the comparator test
    ca_en <= 1'b1;
    acq.comp_ov_fail <= 1'b1;
    acq.comp_uv_fail <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      cfg <= 3'(c);
      idle(1);
      acq.comp_done <= 1'b1;
      idle(1);
      acq.comp_done <= 1'b0;
      rd(A2, (c == 1 || c == 2) ? 16'h0003 : 16'h0000);
      wr(A2, 16'h0000);
    end
    sum_in <= 16'hFFFF;
    idle(2);
    rd(AS, 16'hFFDF);
    wr(AS, 16'h0000);
    rd(AS, 16'hFFDF);
    // Reset in mid-run drops the user alert
    wr(A2, 16'h8000);
    presetn <= 1'b0;
    idle(2);
    presetn <= 1'b1;
    check({31'h0, user_alert}, 32'h0000_0000);
    rd(A2, 16'h0000);
    give_verdict();
  end
endmodule : fault_alert_status_bank_bench
